// [rtl/tkcc_top.sv]
// touch key capture control: apb registers, capture sequencer, interrupts
// assumes apb master in the pclk domain and synchronous analog inputs
//
// How it works
// - busy reads high for whole capture sequence
// - writing start one with enable one begins a capture
// - auto clear: one capture, then stop
// - auto set: repeat captures until touch detected
// - writing start zero while busy aborts
// - mode zero: capacitor clock timer, internal counted
// - mode one: internal clock timer, capacitor counted
// - two-bit field picks main and reference clock
// - auto setting also enables wake on detection
//
// Chosen here: the placing of the registers and the APB interface to the registers.
`timescale 1ns/10ps
module tkcc_top
#(
	parameter int CNT_W = tkcc_pkg::CNT_W
)
(
	// ------------------------------------------------------------
	// apb slave
	// ------------------------------------------------------------
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// ------------------------------------------------------------
	// analog front end and clock sources
	// ------------------------------------------------------------
	input wire logic fast_rc_tick,
	input wire logic pll_tick,
	input wire logic rtc_tick,
	input wire logic slow_rc_tick,
	input wire logic cap_clk_in,
	input wire logic touch_detect,
	input wire logic [CNT_W-1:0] timer_limit,
	output logic [1:0] main_clock_select,
	output logic sense_active,
	output logic wakeup,
	output logic irq
);
	// ------------------------------------------------------------
	// declarations
	// ------------------------------------------------------------
	localparam int EV_W_L = tkcc_pkg::EV_W; // event count, needed by the widths below
	logic sense_enable_reg; // controller enable
	logic mode_reg; // timer/counter mode
	logic [1:0] internal_clock_select_reg; // clock source code
	logic auto_reg; // continuous detect and wake
	logic sense_irq_enable_reg; // interrupt enable
	logic sense_irq_flag_reg; // interrupt flag
	logic seq_run_reg; // capture sequence in progress
	logic det_seen_reg; // detection seen in this sequence
	logic [EV_W_L-1:0] irq_status_reg; // sticky events
	logic [EV_W_L-1:0] irq_mask_reg; // event mask
	logic [EV_W_L-1:0] ev_set; // events this cycle
	logic wakeup_reg; // wake request pulse
	logic [31:0] prdata_reg; // read data for access phase
	logic slverr_reg; // unmapped address flag

	logic setup; // apb setup cycle
	logic access; // apb access cycle
	logic wr_access; // write takes effect
	logic rd_access; // read completes
	logic wr_ctrl; // write to control
	logic wr_mask; // write to mask
	logic rd_status; // read of status, clears it
	logic start_cmd; // start command accepted
	logic abort_cmd; // abort of a running sequence
	logic disable_cmd; // enable dropped
	logic cap_start; // pulse into capture engine
	logic restart; // back-to-back capture in auto
	logic cap_busy; // engine running
	logic cap_done; // engine finished a window
	logic [CNT_W-1:0] cap_count; // last count
	logic base_tick; // timer base edge
	logic count_tick; // counted edge
	logic detect_now; // detection during a sequence
	logic [7:0] ctrl_read; // control register image

	// ------------------------------------------------------------
	// address decode helpers
	// ------------------------------------------------------------

	// true when the address names a mapped register
	function automatic logic addr_hit(input logic [11:0] a);
		addr_hit = (a == tkcc_pkg::OFS_CTRL) || (a == tkcc_pkg::OFS_IRQ_STATUS)
			|| (a == tkcc_pkg::OFS_IRQ_MASK) || (a == tkcc_pkg::OFS_RESULT);
	endfunction

	// ------------------------------------------------------------
	// apb phases
	// ------------------------------------------------------------

	// zero wait state slave: ready in every access phase
	assign setup = psel && !penable;
	assign access = psel && penable;
	assign wr_access = access && pwrite;
	assign rd_access = access && !pwrite;
	assign wr_ctrl = wr_access && (paddr == tkcc_pkg::OFS_CTRL);
	assign wr_mask = wr_access && (paddr == tkcc_pkg::OFS_IRQ_MASK);
	assign rd_status = rd_access && (paddr == tkcc_pkg::OFS_IRQ_STATUS);
	assign pready = 1'b1;
	assign pslverr = access && slverr_reg;
	assign prdata = prdata_reg;

	// ------------------------------------------------------------
	// commands decoded from control writes
	// ------------------------------------------------------------

	// start needs the enable bit in the written value
	assign start_cmd = wr_ctrl && pwdata[tkcc_pkg::BIT_START]
		&& pwdata[tkcc_pkg::BIT_EN] && !seq_run_reg;
	// start zero while running aborts
	assign abort_cmd = wr_ctrl && !pwdata[tkcc_pkg::BIT_START] && seq_run_reg;
	// dropping enable stops any activity
	assign disable_cmd = wr_ctrl && !pwdata[tkcc_pkg::BIT_EN] && seq_run_reg;
	// detection only counts inside a sequence
	assign detect_now = touch_detect && seq_run_reg;
	// auto repeats while no detection has been made
	assign restart = cap_done && auto_reg && seq_run_reg
		&& !det_seen_reg && !detect_now && !abort_cmd && !disable_cmd;
	assign cap_start = start_cmd || restart;

	// ------------------------------------------------------------
	// control register
	// ------------------------------------------------------------

	// software fields of touch_sense_control
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			sense_enable_reg <= tkcc_pkg::CTRL_RST[tkcc_pkg::BIT_EN];
			mode_reg <= tkcc_pkg::CTRL_RST[tkcc_pkg::BIT_MODE];
			internal_clock_select_reg <=
				tkcc_pkg::CTRL_RST[tkcc_pkg::BIT_CKS_HI:tkcc_pkg::BIT_CKS_LO];
			auto_reg <= tkcc_pkg::CTRL_RST[tkcc_pkg::BIT_AUTO];
			sense_irq_enable_reg <= tkcc_pkg::CTRL_RST[tkcc_pkg::BIT_IEN];
		end
		else if (wr_ctrl)
		begin
			sense_enable_reg <= pwdata[tkcc_pkg::BIT_EN];
			mode_reg <= pwdata[tkcc_pkg::BIT_MODE];
			internal_clock_select_reg <=
				pwdata[tkcc_pkg::BIT_CKS_HI:tkcc_pkg::BIT_CKS_LO];
			auto_reg <= pwdata[tkcc_pkg::BIT_AUTO];
			sense_irq_enable_reg <= pwdata[tkcc_pkg::BIT_IEN];
		end
	end

	// interrupt flag: set by hardware, cleared by writing zero
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			sense_irq_flag_reg <= tkcc_pkg::CTRL_RST[tkcc_pkg::BIT_IFLAG];
		else if (cap_done || detect_now)
			sense_irq_flag_reg <= 1'b1;
		else if (wr_ctrl && !pwdata[tkcc_pkg::BIT_IFLAG])
			sense_irq_flag_reg <= 1'b0;
	end

	// ------------------------------------------------------------
	// capture sequencer
	// ------------------------------------------------------------

	// busy covers a single capture or a whole auto run
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			seq_run_reg <= 1'b0;
		else if (start_cmd)
			seq_run_reg <= 1'b1;
		else if (abort_cmd || disable_cmd)
			seq_run_reg <= 1'b0;
		else if (cap_done && !restart)
			seq_run_reg <= 1'b0;
	end

	// remembers a detection until the next start
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			det_seen_reg <= 1'b0;
		else if (start_cmd)
			det_seen_reg <= 1'b0;
		else if (detect_now)
			det_seen_reg <= 1'b1;
	end

	// wake request when auto detection finds a touch
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			wakeup_reg <= 1'b0;
		else
			wakeup_reg <= detect_now && auto_reg;
	end

	assign wakeup = wakeup_reg;
	assign sense_active = seq_run_reg;
	assign main_clock_select = internal_clock_select_reg;

	// ------------------------------------------------------------
	// capture engine and clock routing
	// ------------------------------------------------------------

	// picks timer base and counted edges from mode and source
	tkcc_clksel u_clksel
	(
		.pclk(pclk),
		.presetn(presetn),
		.clock_select(internal_clock_select_reg),
		.mode(mode_reg),
		.fast_rc_tick(fast_rc_tick),
		.pll_tick(pll_tick),
		.rtc_tick(rtc_tick),
		.slow_rc_tick(slow_rc_tick),
		.cap_clk_in(cap_clk_in),
		.base_tick(base_tick),
		.count_tick(count_tick)
	);

	// one capture window per start pulse
	tkcc_capture #(.CNT_W(CNT_W)) u_capture
	(
		.pclk(pclk),
		.presetn(presetn),
		.start(cap_start),
		.abort(abort_cmd || disable_cmd),
		.base_tick(base_tick),
		.count_tick(count_tick),
		.timer_limit(timer_limit),
		.busy(cap_busy),
		.done(cap_done),
		.count_value(cap_count)
	);

	// ------------------------------------------------------------
	// interrupt status and mask
	// ------------------------------------------------------------

	// events of this cycle
	always_comb
	begin
		ev_set = '0;
		ev_set[tkcc_pkg::EV_DONE] = cap_done;
		ev_set[tkcc_pkg::EV_DETECT] = detect_now;
		ev_set[tkcc_pkg::EV_ABORT] = abort_cmd || disable_cmd;
	end

	// sticky status, cleared by read; a new event wins over the clear
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			irq_status_reg <= tkcc_pkg::EV_RST;
		else if (rd_status)
			irq_status_reg <= ev_set;
		else
			irq_status_reg <= irq_status_reg | ev_set;
	end

	// mask register, one bit per event
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			irq_mask_reg <= tkcc_pkg::EV_RST;
		else if (wr_mask)
			irq_mask_reg <= pwdata[EV_W_L-1:0];
	end

	// level interrupt, gated by the enable bit
	assign irq = sense_irq_enable_reg
		&& (sense_irq_flag_reg || (|(irq_status_reg & irq_mask_reg)));

	// ------------------------------------------------------------
	// read data
	// ------------------------------------------------------------

	// control image, busy in the start position
	always_comb
	begin
		ctrl_read = '0;
		ctrl_read[tkcc_pkg::BIT_EN] = sense_enable_reg;
		ctrl_read[tkcc_pkg::BIT_MODE] = mode_reg;
		ctrl_read[tkcc_pkg::BIT_CKS_HI:tkcc_pkg::BIT_CKS_LO] = internal_clock_select_reg;
		ctrl_read[tkcc_pkg::BIT_AUTO] = auto_reg;
		ctrl_read[tkcc_pkg::BIT_IEN] = sense_irq_enable_reg;
		ctrl_read[tkcc_pkg::BIT_IFLAG] = sense_irq_flag_reg;
		ctrl_read[tkcc_pkg::BIT_START] = seq_run_reg || cap_busy;
	end

	// read data loaded in setup so it stands through access
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata_reg <= 32'h0000_0000;
			slverr_reg <= 1'b0;
		end
		else if (setup)
		begin
			slverr_reg <= !addr_hit(paddr);
			prdata_reg <= 32'h0000_0000;
			if (!pwrite)
			begin
				unique case (paddr)
					tkcc_pkg::OFS_CTRL: prdata_reg <= {24'h00_0000, ctrl_read};
					tkcc_pkg::OFS_IRQ_STATUS:
						prdata_reg <= {{(32-EV_W_L){1'b0}}, irq_status_reg | ev_set};
					tkcc_pkg::OFS_IRQ_MASK:
						prdata_reg <= {{(32-EV_W_L){1'b0}}, irq_mask_reg};
					tkcc_pkg::OFS_RESULT:
						prdata_reg <= {{(32-CNT_W){1'b0}}, cap_count};
					default: prdata_reg <= 32'h0000_0000;
				endcase
			end
		end
	end
endmodule

// [inc/tkcc_pkg.sv]
// touch key capture control: register map, field positions, reset values
// assumes a 32-bit apb slave with 12-bit byte addresses
package tkcc_pkg;
	// ------------------------------------------------------------
	// register byte offsets
	// ------------------------------------------------------------
	localparam logic [11:0] OFS_CTRL = 12'h000; // touch_sense_control
	localparam logic [11:0] OFS_IRQ_STATUS = 12'h004; // sticky events, read clears
	localparam logic [11:0] OFS_IRQ_MASK = 12'h008; // event mask, same layout
	localparam logic [11:0] OFS_RESULT = 12'h00c; // last capture count
	// ------------------------------------------------------------
	// control register fields
	// ------------------------------------------------------------
	localparam int BIT_EN = 7; // sense_enable
	localparam int BIT_MODE = 6; // timer/counter mode
	localparam int BIT_CKS_HI = 5; // internal_clock_select msb
	localparam int BIT_CKS_LO = 4; // internal_clock_select lsb
	localparam int BIT_AUTO = 3; // continuous detect and wake
	localparam int BIT_IEN = 2; // sense_irq_enable
	localparam int BIT_IFLAG = 1; // sense_irq_flag
	localparam int BIT_START = 0; // write start, read busy
	localparam logic [7:0] CTRL_RST = 8'h00;
	// ------------------------------------------------------------
	// internal clock select codes
	// ------------------------------------------------------------
	localparam logic [1:0] CKS_FAST_RC = 2'h0; // fast_rc_oscillator
	localparam logic [1:0] CKS_PLL = 2'h1;
	localparam logic [1:0] CKS_RTC = 2'h2;
	localparam logic [1:0] CKS_SLOW_RC = 2'h3; // slow_rc_oscillator
	// ------------------------------------------------------------
	// interrupt status bits
	// ------------------------------------------------------------
	localparam int EV_DONE = 0; // capture completed
	localparam int EV_DETECT = 1; // touch detection made
	localparam int EV_ABORT = 2; // capture aborted
	localparam int EV_W = 3;
	localparam logic [EV_W-1:0] EV_RST = 3'h0;
	// ------------------------------------------------------------
	// widths
	// ------------------------------------------------------------
	localparam int CNT_W = 16; // timer and counter width
endpackage

// [rtl/tkcc_clksel.sv]
// touch key capture control: reference clock select and timer/counter routing
// assumes oscillator ticks and the capacitor clock are synchronous to pclk
`timescale 1ns/10ps
module tkcc_clksel
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [1:0] clock_select,
	input wire logic mode,
	input wire logic fast_rc_tick,
	input wire logic pll_tick,
	input wire logic rtc_tick,
	input wire logic slow_rc_tick,
	input wire logic cap_clk_in,
	output logic base_tick,
	output logic count_tick
);
	logic cap_prev_reg; // capacitor clock of last cycle
	logic cap_rise; // capacitor clock rising edge
	logic ref_tick; // selected internal reference tick

	// picks one of the four internal sources
	function automatic logic pick_ref(input logic [1:0] sel, input logic [3:0] t);
		pick_ref = t[sel];
	endfunction

	// remembers the capacitor clock for edge detection
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			cap_prev_reg <= 1'b0;
		else
			cap_prev_reg <= cap_clk_in;
	end

	// routes edges to the timer base and the counter
	always_comb
	begin
		cap_rise = cap_clk_in & ~cap_prev_reg;
		ref_tick = pick_ref(clock_select, {slow_rc_tick, rtc_tick, pll_tick, fast_rc_tick});
		if (mode)
		begin
			base_tick = ref_tick;
			count_tick = cap_rise;
		end
		else
		begin
			base_tick = cap_rise;
			count_tick = ref_tick;
		end
	end
endmodule

// [rtl/tkcc_capture.sv]
// touch key capture control: one capture, timer window and edge counter
// assumes start and abort are one-cycle pulses from the sequencer
`timescale 1ns/10ps
module tkcc_capture
#(
	parameter int CNT_W = tkcc_pkg::CNT_W
)
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic start,
	input wire logic abort,
	input wire logic base_tick,
	input wire logic count_tick,
	input wire logic [CNT_W-1:0] timer_limit,
	output logic busy,
	output logic done,
	output logic [CNT_W-1:0] count_value
);
	typedef enum logic {TKCC_IDLE, TKCC_RUN} tkcc_cap_e;
	tkcc_cap_e state_reg; // capture state
	logic [CNT_W-1:0] timer_reg; // base edges seen so far
	logic [CNT_W-1:0] count_reg; // counted edges so far
	logic window_end; // last base edge of the window
	logic done_reg; // completion pulse

	assign window_end = (state_reg == TKCC_RUN) && base_tick && !abort
		&& (timer_reg + 1'b1 >= timer_limit);
	assign busy = (state_reg == TKCC_RUN);
	assign done = done_reg;

	// capture state: start enters, window end or abort leaves
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			state_reg <= TKCC_IDLE;
		else
		begin
			unique case (state_reg)
				TKCC_IDLE: if (start) state_reg <= TKCC_RUN;
				TKCC_RUN: if (abort || window_end) state_reg <= TKCC_IDLE;
			endcase
		end
	end

	// timer and counter, cleared on start
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			timer_reg <= '0;
			count_reg <= '0;
		end
		else if (start && state_reg == TKCC_IDLE)
		begin
			timer_reg <= '0;
			count_reg <= '0;
		end
		else if (state_reg == TKCC_RUN)
		begin
			if (base_tick)
				timer_reg <= timer_reg + 1'b1;
			if (count_tick)
				count_reg <= count_reg + 1'b1;
		end
	end

	// result latch and completion pulse
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			done_reg <= 1'b0;
			count_value <= '0;
		end
		else
		begin
			done_reg <= window_end;
			if (window_end)
				count_value <= count_reg + {{(CNT_W-1){1'b0}}, count_tick};
		end
	end
endmodule

// [tb/tkcc_top_checker.sv]
// tkcc_top_checker: port level properties of the capture control block
// assumes a single pclk domain and reset presetn, bound into tkcc_top
`timescale 1ns/10ps
module tkcc_top_checker
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic touch_detect,
	input wire logic [1:0] main_clock_select,
	input wire logic sense_active,
	input wire logic wakeup,
	input wire logic irq
);
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	logic wr_ctrl; // control write taking effect
	assign wr_ctrl = psel & penable & pwrite & (paddr == tkcc_pkg::OFS_CTRL);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	// ----------------------------------------
	// properties
	// ----------------------------------------
	a_start_busy: assert property (wr_ctrl && pwdata[0] && pwdata[7] && !sense_active
		|=> sense_active) else $error("start did not raise busy");
	a_busy_cause: assert property ($rose(sense_active)
		|-> $past(wr_ctrl && pwdata[0] && pwdata[7])) else $error("busy rose without start");
	a_abort_idle: assert property (wr_ctrl && pwdata[7] && !pwdata[0] && sense_active
		|=> !sense_active) else $error("abort left busy");
	a_disable_idle: assert property (wr_ctrl && !pwdata[7]
		|=> !sense_active) else $error("disabled block busy");
	a_clock_field: assert property (wr_ctrl
		|=> main_clock_select == $past(pwdata[5:4])) else $error("clock select wrong");
	a_wake_pulse: assert property (wakeup
		|-> $past(touch_detect) ##1 !wakeup) else $error("wakeup not a detect pulse");
	a_irq_off: assert property (wr_ctrl && !pwdata[2]
		|=> !irq) else $error("irq with enable clear");
	a_unmapped_err: assert property (psel && penable && paddr > 12'h00c
		|-> pslverr) else $error("no error on unmapped address");
	a_ready_high: assert property (psel && penable
		|-> pready) else $error("pready low in access");
endmodule
bind tkcc_top tkcc_top_checker u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
	.pslverr(pslverr), .touch_detect(touch_detect), .main_clock_select(main_clock_select),
	.sense_active(sense_active), .wakeup(wakeup), .irq(irq));

// [tb/tkcc_afe_model.sv]
// tkcc_afe_model: behavioural electrode front end and clock sources
// assumes pclk domain; touch_req comes from the bench
`timescale 1ns/10ps
module tkcc_afe_model
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic touch_req,
	output logic cap_clk_in,
	output logic touch_detect,
	output logic [3:0] ticks
);
	logic [7:0] cnt_reg; // free running divider
	// divider advances every pclk
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			cnt_reg <= 8'h00;
		else
			cnt_reg <= cnt_reg + 8'h01;
	end
	// charge/discharge period of eight pclk
	assign cap_clk_in = cnt_reg[2];
	// one-cycle ticks: fast, pll, rtc, slow at unlike rates
	assign ticks[0] = cnt_reg[0];
	assign ticks[1] = (cnt_reg[1:0] == 2'h3);
	assign ticks[2] = (cnt_reg[4:0] == 5'h1f);
	assign ticks[3] = (cnt_reg[2:0] == 3'h7);
	// comparator reports a touch only when commanded
	assign touch_detect = touch_req;
endmodule

// [tb/touch_key_capture_control_tb.sv]
// touch_key_capture_control_tb: self-checking bench for tkcc_top
// assumes the front end model and the bound checker
`timescale 1ns/10ps
module touch_key_capture_control_tb;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rdata;
	logic rerr, cap_clk_in, touch_detect, touch_req, wakeup, irq, sense_active;
	logic [3:0] ticks;
	logic [15:0] timer_limit;
	logic [1:0] main_clock_select;
	int error_cnt = 0;
	int n_tests = 0;
	int wake_cnt = 0; // wakeup pulses seen
	// table rows: control write, clock field, readback
	logic [7:0] row_w[4] = '{8'h00, 8'h14, 8'h68, 8'h7c};
	logic [1:0] row_cks[4] = '{2'h0, 2'h1, 2'h2, 2'h3};
	logic [7:0] row_rd[4] = '{8'h00, 8'h14, 8'h68, 8'h7c};
	tkcc_afe_model u_afe (.pclk(pclk), .presetn(presetn), .touch_req(touch_req),
		.cap_clk_in(cap_clk_in), .touch_detect(touch_detect), .ticks(ticks));
	tkcc_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .fast_rc_tick(ticks[0]), .pll_tick(ticks[1]), .rtc_tick(ticks[2]),
		.slow_rc_tick(ticks[3]), .cap_clk_in(cap_clk_in), .touch_detect(touch_detect),
		.timer_limit(timer_limit), .main_clock_select(main_clock_select),
		.sense_active(sense_active), .wakeup(wakeup), .irq(irq));
	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic summarize();
		if (error_cnt == 0 && n_tests > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// one apb transfer; holds the request until pready is sampled
	task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
		begin
			@(posedge pclk);
		end
		while (pready !== 1'b1);
		rdata = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// write control, then look at busy once the access edge has landed
	task automatic start(input logic [7:0] v);
		apb(tkcc_pkg::OFS_CTRL, 1'b1, {24'h0, v});
		@(negedge pclk);
	endtask
	// bounded wait for the capture sequence to end
	task automatic wait_idle();
		int n;
		n = 0;
		while (sense_active !== 1'b0 && n < 400)
		begin
			@(negedge pclk);
			n++;
		end
		chk("capture end", sense_active, 0);
	endtask
	// ----------------------------------------
	// clock, watchdog, monitor
	// ----------------------------------------
	initial
	begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end
	initial
	begin
		repeat (20000) @(posedge pclk);
		error_cnt++;
		summarize();
	end
	always @(negedge pclk)
		if (wakeup === 1'b1)
			wake_cnt++;
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial
	begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		touch_req = 1'b0;
		timer_limit = 16'h0004;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		@(negedge pclk);
		chk("irq", irq, 0);
		chk("busy", sense_active, 0);
		for (int i = 0; i < 3; i++)
		begin
			apb(12'h000 + 12'(4 * i), 1'b0, 32'h0);
			chk("reset value", rdata, 0);
		end
		apb(12'h010, 1'b0, 32'h0);
		chk("unmapped data", rdata, 0);
		chk("unmapped err", rerr, 1);
		for (int i = 0; i < 4; i++)
		begin
			start(row_w[i]);
			chk("clock select", main_clock_select, row_cks[i]);
			apb(tkcc_pkg::OFS_CTRL, 1'b0, 32'h0);
			chk("ctrl readback", rdata, row_rd[i]);
		end
		// single capture, mode 0, interrupt enabled
		apb(tkcc_pkg::OFS_IRQ_MASK, 1'b1, 32'h1);
		start(8'h85);
		chk("busy on start", sense_active, 1);
		wait_idle();
		repeat (80) @(negedge pclk);
		chk("one capture", sense_active, 0);
		chk("irq raised", irq, 1);
		// four capacitor periods of eight cycles, fast tick every other cycle
		apb(tkcc_pkg::OFS_RESULT, 1'b0, 32'h0);
		chk("mode 0 count", rdata >= 32'h0000000c && rdata <= 32'h00000010, 1);
		apb(tkcc_pkg::OFS_IRQ_STATUS, 1'b0, 32'h0);
		chk("done event", rdata, 32'h1);
		apb(tkcc_pkg::OFS_IRQ_STATUS, 1'b0, 32'h0);
		chk("status cleared", rdata, 0);
		apb(tkcc_pkg::OFS_CTRL, 1'b0, 32'h0);
		chk("flag set", rdata, 32'h86);
		start(8'h82);
		chk("irq disabled", irq, 0);
		start(8'h86);
		chk("irq back", irq, 1);
		start(8'h84);
		chk("irq cleared", irq, 0);
		// mode 1 on the slow oscillator
		start(8'hf1);
		chk("busy mode 1", sense_active, 1);
		wait_idle();
		apb(tkcc_pkg::OFS_IRQ_STATUS, 1'b0, 32'h0);
		chk("mode 1 done", rdata, 32'h1);
		// four slow ticks of window, one capacitor rise per tick period
		apb(tkcc_pkg::OFS_RESULT, 1'b0, 32'h0);
		chk("mode 1 count", rdata >= 32'h00000003 && rdata <= 32'h00000004, 1);
		// continuous capture until a touch
		start(8'h89);
		repeat (200) @(negedge pclk);
		chk("still capturing", sense_active, 1);
		@(posedge pclk);
		touch_req <= 1'b1;
		@(posedge pclk);
		touch_req <= 1'b0;
		wait_idle();
		chk("wake pulses", wake_cnt, 1);
		apb(tkcc_pkg::OFS_IRQ_STATUS, 1'b0, 32'h0);
		chk("detect event", rdata, 32'h3);
		// abort by start zero, then by disable
		@(posedge pclk);
		timer_limit <= 16'hff00;
		start(8'h81);
		start(8'h80);
		chk("aborted", sense_active, 0);
		apb(tkcc_pkg::OFS_IRQ_STATUS, 1'b0, 32'h0);
		chk("abort event", rdata, 32'h4);
		start(8'h81);
		start(8'h00);
		chk("disabled", sense_active, 0);
		start(8'h01);
		chk("start ignored", sense_active, 0);
		// reset in the middle of a capture
		start(8'h81);
		@(posedge pclk);
		presetn <= 1'b0;
		@(negedge pclk);
		chk("reset busy", sense_active, 0);
		@(posedge pclk);
		presetn <= 1'b1;
		@(negedge pclk);
		chk("reset irq", irq, 0);
		apb(tkcc_pkg::OFS_CTRL, 1'b0, 32'h0);
		chk("reset ctrl", rdata, 0);
		apb(tkcc_pkg::OFS_IRQ_STATUS, 1'b0, 32'h0);
		chk("reset status", rdata, 0);
		summarize();
	end
endmodule
